/* File: pwc_pkg.sv */
package pwc_pkg;
	// ----------------------------------------------------------------
	// sizes and register map
	// ----------------------------------------------------------------
	localparam int PORT_N = 3;
	localparam int TMR_W = 26;
	localparam int ADDR_W = 8;
	localparam int BLK_W = 8;
	localparam int CLK_W = 3;
	localparam logic [ADDR_W-1:0] OFS_PWRCTL = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_CMD = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_STAT = 8'h08;
	localparam logic [15:0] CLKOFF_RST = 16'h0535;
	localparam logic [BLK_W-1:0] BLK_RST = 8'h00;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_NS = 20;
	localparam int LP_HALF_NS = 5000;
	localparam int LP_HALF_CYC = LP_HALF_NS / CLK_NS;
	localparam int LOCK_NS = 50000;
	localparam int LOCK_CYC = LOCK_NS / CLK_NS;
	localparam int CLKOFF_UNIT_NS = 7500;
	localparam int SUSP_DLY_MS = 100;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {ST_RUN, ST_SUSP, ST_LOCK, ST_RESUME} pwc_st_e;

	typedef struct packed {
		logic host_n;
		logic periph_n;
		logic cs_n;
		logic [PORT_N-1:0] conn;
	} pwc_wake_s;

	typedef struct packed {
		pwc_st_e st;
		logic pready;
		logic [31:0] prdata;
		logic pslverr;
		logic [15:0] clkoff;
		logic [BLK_W-1:0] blk_off;
		logic run_stop;
		logic irq;
		logic [7:0] lpdiv;
		logic lposc;
		pwc_wake_s s1;
		pwc_wake_s s2;
		logic [PORT_N-1:0] conn_prev;
		logic [TMR_W-1:0] tmr;
		logic hwk;
		logic pwk;
		logic pin_oe;
		logic [CLK_W-1:0] clk_en;
	} pwc_state_s;
endpackage : pwc_pkg

/* File: pwc_top.sv */
// The APB slave port and the register offsets are this design's own decisions.
`timescale 1ns/100ps
module pwc_top import pwc_pkg::*; #(
	parameter int SUSP_DLY_CYC = SUSP_DLY_MS * 1000000 / CLK_NS,
	parameter int CLKOFF_UNIT_CYC = CLKOFF_UNIT_NS / CLK_NS
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic host_sleep_wake_pin_n_i,
	output logic host_sleep_wake_pin_n_o,
	output logic host_sleep_wake_pin_n_oe,
	input wire logic periph_sleep_wake_pin_n_i,
	output logic periph_sleep_wake_pin_n_o,
	output logic periph_sleep_wake_pin_n_oe,
	input wire logic cs_n,
	input wire logic [PORT_N-1:0] port_connected,
	output logic low_power_oscillator,
	output logic [CLK_W-1:0] main_clk_en,
	output logic [BLK_W-1:0] block_off,
	output logic host_woken,
	output logic periph_woken,
	output logic clocks_running_irq
);
	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	pwc_state_s q;
	pwc_state_s d;
	logic lp_tick;
	logic setup;
	logic wr;
	logic win_done;
	logic [TMR_W-1:0] win_len;
	logic wk_h;
	logic wk_p;
	logic wk_cs;
	logic wk_c;
	logic wk_ok;

	// own pin drive echoes through the synchroniser for two cycles after suspend entry
	localparam int SYNC_SETTLE = 2;

	assign lp_tick = q.lpdiv == 8'(LP_HALF_CYC - 1);
	assign setup = psel && !penable;
	assign wr = psel && penable && q.pready && pwrite && !q.pslverr;
	assign win_len = TMR_W'(q.clkoff * CLKOFF_UNIT_CYC);
	assign win_done = (q.tmr + TMR_W'(1)) >= win_len;
	assign wk_h = !q.s2.host_n;
	assign wk_p = !q.s2.periph_n;
	assign wk_cs = !q.s2.cs_n;
	assign wk_c = q.s2.conn != q.conn_prev;
	assign wk_ok = q.tmr == TMR_W'(SYNC_SETTLE);

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		d = q;
		// free-running oscillator, never gated
		d.lpdiv = lp_tick ? 8'h00 : q.lpdiv + 8'h01;
		if (lp_tick) begin
			d.lposc = !q.lposc;
		end
		// reference tracks the level while awake, so no false edge on suspend entry
		if (lp_tick || q.st != ST_SUSP) begin
			d.conn_prev = q.s2.conn;
		end
		d.s1 = {host_sleep_wake_pin_n_i, periph_sleep_wake_pin_n_i, cs_n, port_connected};
		d.s2 = q.s1;
		// apb slave, answer in the access cycle
		d.pready = setup;
		d.pslverr = 1'b0;
		d.prdata = 32'h0000_0000;
		if (setup) begin
			unique case (paddr)
				OFS_PWRCTL: d.prdata = {q.clkoff, 8'h00, q.blk_off};
				OFS_CMD: d.prdata = {31'h0000_0000, q.run_stop};
				OFS_STAT: d.prdata = {22'h00_0000, q.pwk, q.hwk, 2'h0, q.st, 3'h0, q.irq};
				default: d.pslverr = 1'b1;
			endcase
		end
		if (wr) begin
			unique case (paddr)
				OFS_PWRCTL: begin
					d.clkoff = pwdata[31:16];
					d.blk_off = pwdata[BLK_W-1:0];
				end
				OFS_CMD: d.run_stop = pwdata[0];
				OFS_STAT: if (pwdata[0]) d.irq = 1'b0;
				default: d.irq = q.irq;
			endcase
		end
		// power sequencer
		unique case (q.st)
			ST_RUN: begin
				if (q.run_stop) begin
					d.tmr = '0;
				end else if (q.tmr == TMR_W'(SUSP_DLY_CYC - 1)) begin
					d.st = ST_SUSP;
					d.tmr = '0;
				end else begin
					d.tmr = q.tmr + TMR_W'(1);
				end
			end
			ST_SUSP: begin
				if (!wk_ok) begin
					d.tmr = q.tmr + TMR_W'(1);
				end else if (lp_tick && (wk_h || wk_p || wk_cs || wk_c)) begin
					d.st = ST_LOCK;
					d.hwk = wk_h;
					d.pwk = wk_p;
					d.tmr = '0;
				end
			end
			ST_LOCK: begin
				if (q.tmr == TMR_W'(LOCK_CYC - 1)) begin
					d.st = ST_RESUME;
					d.irq = 1'b1;
					d.tmr = '0;
				end else begin
					d.tmr = q.tmr + TMR_W'(1);
				end
			end
			ST_RESUME: begin
				if (q.run_stop) begin
					d.st = ST_RUN;
					d.tmr = '0;
				end else if (win_done) begin
					d.st = ST_SUSP;
					d.tmr = '0;
				end else begin
					d.tmr = q.tmr + TMR_W'(1);
				end
			end
		endcase
		d.pin_oe = d.st != ST_SUSP;
		d.clk_en = (d.st != ST_SUSP) ? ~d.blk_off[CLK_W-1:0] : '0;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= '{st: ST_RUN, pready: 1'b0, prdata: 32'h0000_0000, pslverr: 1'b0,
				clkoff: CLKOFF_RST, blk_off: BLK_RST, run_stop: 1'b0, irq: 1'b0,
				lpdiv: 8'h00, lposc: 1'b0, s1: '1, s2: '1, conn_prev: '1,
				tmr: '0, hwk: 1'b0, pwk: 1'b0, pin_oe: 1'b1, clk_en: '1};
		end else begin
			q <= d;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign prdata = q.prdata;
	assign pready = q.pready;
	assign pslverr = q.pslverr;
	assign host_sleep_wake_pin_n_o = 1'b0;
	assign periph_sleep_wake_pin_n_o = 1'b0;
	assign host_sleep_wake_pin_n_oe = q.pin_oe;
	assign periph_sleep_wake_pin_n_oe = q.pin_oe;
	assign low_power_oscillator = q.lposc;
	assign main_clk_en = q.clk_en;
	assign block_off = q.blk_off;
	assign host_woken = q.hwk;
	assign periph_woken = q.pwk;
	assign clocks_running_irq = q.irq;

	// ----------------------------------------------------------------
	// check helpers
	// ----------------------------------------------------------------
	localparam int WAIT_W = 13;
	localparam int IRQ_MAX_NS = 100000;
	localparam int IRQ_MAX_CYC = IRQ_MAX_NS / CLK_NS;
	logic [WAIT_W-1:0] irq_wait_q;
	logic [WAIT_W-1:0] irq_wait_d;

	// cycles spent waiting for the clocks, dropping back to zero after all ones
	always_comb begin
		irq_wait_d = '0;
		if (q.st == ST_LOCK && irq_wait_q != '1) begin
			irq_wait_d = irq_wait_q + WAIT_W'(1);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_wait_q <= '0;
		end else begin
			irq_wait_q <= irq_wait_d;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	property p_susp_release;
		@(posedge pclk) disable iff (!presetn)
		q.st == ST_SUSP |-> !host_sleep_wake_pin_n_oe && !periph_sleep_wake_pin_n_oe;
	endproperty
	a_susp_release: assert property (p_susp_release) else $error("pins driven in suspend");

	property p_awake_low;
		@(posedge pclk) disable iff (!presetn)
		q.st != ST_SUSP |-> host_sleep_wake_pin_n_oe && !host_sleep_wake_pin_n_o;
	endproperty
	a_awake_low: assert property (p_awake_low) else $error("awake pin not driven low");

	property p_clk_stop;
		@(posedge pclk) disable iff (!presetn)
		q.st == ST_SUSP |-> main_clk_en == '0;
	endproperty
	a_clk_stop: assert property (p_clk_stop) else $error("main clocks run in suspend");

	property p_irq_ready;
		@(posedge pclk) disable iff (!presetn)
		q.st == ST_LOCK |-> irq_wait_q < WAIT_W'(IRQ_MAX_CYC);
	endproperty
	a_irq_ready: assert property (p_irq_ready) else $error("clocks ready late");

	property p_run_win;
		@(posedge pclk) disable iff (!presetn)
		q.st == ST_RESUME && q.run_stop |=> q.st == ST_RUN;
	endproperty
	a_run_win: assert property (p_run_win) else $error("run/stop ignored in window");

	property p_win_exp;
		@(posedge pclk) disable iff (!presetn)
		q.st == ST_RESUME && !q.run_stop && win_done |=> q.st == ST_SUSP && !host_sleep_wake_pin_n_oe;
	endproperty
	a_win_exp: assert property (p_win_exp) else $error("no return to suspend");

	property p_pin_wake;
		@(posedge pclk) disable iff (!presetn)
		q.st == ST_SUSP && lp_tick && wk_ok && !q.s2.host_n |=> q.st == ST_LOCK && host_woken
			##1 main_clk_en != $past(main_clk_en, 2) || block_off[CLK_W-1:0] == '1;
	endproperty
	a_pin_wake: assert property (p_pin_wake) else $error("pin wake missed");

	property p_lp_osc;
		@(posedge pclk) disable iff (!presetn)
		lp_tick |=> $changed(low_power_oscillator) ##1 $stable(low_power_oscillator);
	endproperty
	a_lp_osc: assert property (p_lp_osc) else $error("oscillator stalled");

	property p_idle_susp;
		@(posedge pclk) disable iff (!presetn)
		q.st == ST_RUN && !q.run_stop && q.tmr == TMR_W'(SUSP_DLY_CYC - 1) |=> q.st == ST_SUSP;
	endproperty
	a_idle_susp: assert property (p_idle_susp) else $error("idle fallback missed");

	property p_blk_wr;
		@(posedge pclk) disable iff (!presetn)
		wr && paddr == OFS_PWRCTL |=> block_off == $past(pwdata[BLK_W-1:0])
			##1 main_clk_en == '0 || main_clk_en == ~block_off[CLK_W-1:0];
	endproperty
	a_blk_wr: assert property (p_blk_wr) else $error("block disable not applied");

	property p_irq_set;
		@(posedge pclk) disable iff (!presetn)
		q.st == ST_LOCK ##1 q.st == ST_RESUME |-> clocks_running_irq;
	endproperty
	a_irq_set: assert property (p_irq_set) else $error("resume without clocks ready");

	property p_cs_wake;
		@(posedge pclk) disable iff (!presetn)
		q.st == ST_SUSP && lp_tick && wk_ok && wk_cs && !wk_h && !wk_p
			|=> q.st == ST_LOCK && !host_woken && !periph_woken;
	endproperty
	a_cs_wake: assert property (p_cs_wake) else $error("chip select wake missed");

	property p_periph_wake;
		@(posedge pclk) disable iff (!presetn)
		q.st == ST_SUSP && lp_tick && wk_ok && wk_p |=> q.st == ST_LOCK && periph_woken;
	endproperty
	a_periph_wake: assert property (p_periph_wake) else $error("peripheral pin wake missed");

	property p_attach_wake;
		@(posedge pclk) disable iff (!presetn)
		q.st == ST_SUSP && lp_tick && wk_ok && wk_c |=> q.st == ST_LOCK;
	endproperty
	a_attach_wake: assert property (p_attach_wake) else $error("attach wake missed");

	property p_sync_pipe;
		@(posedge pclk) disable iff (!presetn)
		q.s2 == $past(q.s1);
	endproperty
	a_sync_pipe: assert property (p_sync_pipe) else $error("wake synchroniser skipped");

	property p_susp_quiet;
		@(posedge pclk) disable iff (!presetn)
		q.st == ST_SUSP && q.s2.host_n && q.s2.periph_n && q.s2.cs_n && !wk_c |=> q.st == ST_SUSP;
	endproperty
	a_susp_quiet: assert property (p_susp_quiet) else $error("wake without cause");

	property p_clk_run;
		@(posedge pclk) disable iff (!presetn)
		q.st != ST_SUSP |-> main_clk_en == ~block_off[CLK_W-1:0];
	endproperty
	a_clk_run: assert property (p_clk_run) else $error("main clocks off while awake");

	property p_win_hold;
		@(posedge pclk) disable iff (!presetn)
		q.st == ST_RESUME && !q.run_stop && !win_done |=> q.st == ST_RESUME;
	endproperty
	a_win_hold: assert property (p_win_hold) else $error("resume window cut short");

	property p_irq_sticky;
		@(posedge pclk) disable iff (!presetn)
		clocks_running_irq && !(wr && paddr == OFS_STAT && pwdata[0]) |=> clocks_running_irq;
	endproperty
	a_irq_sticky: assert property (p_irq_sticky) else $error("clocks ready dropped");

	property p_awake_low_p;
		@(posedge pclk) disable iff (!presetn)
		q.st != ST_SUSP |-> periph_sleep_wake_pin_n_oe && !periph_sleep_wake_pin_n_o;
	endproperty
	a_awake_low_p: assert property (p_awake_low_p) else $error("awake peripheral pin not low");

	c_wake: cover property (@(posedge pclk) disable iff (!presetn) q.st == ST_SUSP ##1 q.st == ST_LOCK);
	c_run: cover property (@(posedge pclk) disable iff (!presetn) q.st == ST_RESUME ##1 q.st == ST_RUN);
	c_back: cover property (@(posedge pclk) disable iff (!presetn) q.st == ST_RESUME ##1 q.st == ST_SUSP);
	c_pwake: cover property (@(posedge pclk) disable iff (!presetn) q.st == ST_SUSP ##1 periph_woken);
	c_clear: cover property (@(posedge pclk) disable iff (!presetn) clocks_running_irq ##1 !clocks_running_irq);
endmodule : pwc_top

/* File: pwc_gpio_model.sv */
`timescale 1ns/100ps
module pwc_gpio_model (
	input wire logic host_pull,
	input wire logic periph_pull,
	input wire logic host_oe,
	input wire logic host_o,
	input wire logic periph_oe,
	input wire logic periph_o,
	output logic host_pin,
	output logic periph_pin
);
	// ----------------------------------------------------------------
	// wired pin: device, processor gpio, external pull-up
	// ----------------------------------------------------------------
	// gpio is an input unless pulling low; pull-up wins when nobody drives
	assign host_pin = !((host_oe && !host_o) || host_pull);
	assign periph_pin = !((periph_oe && !periph_o) || periph_pull);
endmodule : pwc_gpio_model

/* File: suspend_wake_power_control_bench.sv */
`timescale 1ns/100ps
module suspend_wake_power_control_bench import pwc_pkg::*;;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, o;
	logic [7:0] paddr, block_off;
	logic [31:0] pwdata, prdata, rd;
	logic host_pull, periph_pull, cs_n, hpin, ppin, h_o, h_oe, p_o, p_oe;
	logic low_power_oscillator, host_woken, periph_woken, clocks_running_irq;
	logic [2:0] port_connected, main_clk_en;
	int num_errors = 0;
	int checks_done = 0;
	int cyc = 0;
	// hybrid power-up reset pulse, scaled down from 2 ms
	localparam int HYB_RST_CYC = 100;

	pwc_top #(.SUSP_DLY_CYC(200), .CLKOFF_UNIT_CYC(2)) u_dut (.pclk, .presetn, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .host_sleep_wake_pin_n_i(hpin),
		.host_sleep_wake_pin_n_o(h_o), .host_sleep_wake_pin_n_oe(h_oe), .periph_sleep_wake_pin_n_i(ppin),
		.periph_sleep_wake_pin_n_o(p_o), .periph_sleep_wake_pin_n_oe(p_oe), .cs_n, .port_connected,
		.low_power_oscillator, .main_clk_en, .block_off, .host_woken, .periph_woken, .clocks_running_irq);
	pwc_gpio_model u_gpio (.host_pull, .periph_pull, .host_oe(h_oe), .host_o(h_o), .periph_oe(p_oe),
		.periph_o(p_o), .host_pin(hpin), .periph_pin(ppin));

	// ----------------------------------------------------------------
	// clock, timeout, report
	// ----------------------------------------------------------------
	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end

	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			num_errors++;
			print_verdict();
		end
	end

	task print_verdict;
		$display("counts: %0d mismatches, %0d checks", num_errors, checks_done);
		if (num_errors == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : print_verdict

	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// apb transfer; pready and read data taken at the completing rising edge
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1)
			chk("pready", 1, pready);
	endtask : apb

	// ----------------------------------------------------------------
	// tests
	// ----------------------------------------------------------------
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		host_pull = 1'b0;
		periph_pull = 1'b0;
		cs_n = 1'b1;
		port_connected = 3'h0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		@(negedge pclk);
		chk("main_clk_en", 3'h7, main_clk_en);
		chk("host_oe", 1, h_oe);
		apb(0, OFS_PWRCTL, 0);
		chk("pwrctl", {CLKOFF_RST, 16'h0}, rd);
		apb(0, 8'h0c, 0);
		chk("pslverr", 1, err);
		apb(1, OFS_PWRCTL, 32'h00100001);
		apb(0, OFS_PWRCTL, 0);
		chk("pwrctl", 32'h00100001, rd);
		chk("main_clk_en", 3'h6, main_clk_en);
		chk("block_off", 8'h01, block_off);
		$display("test registers done");
		for (int s = 0; s < 4; s++) begin
			repeat (260) @(negedge pclk);
			o = low_power_oscillator;
			chk("main_clk_en", 3'h0, main_clk_en);
			chk("host_oe", 0, h_oe);
			chk("periph_oe", 0, p_oe);
			chk("host_pin", 1, hpin);
			repeat (250) @(negedge pclk);
			chk("oscillator", !o, low_power_oscillator);
			@(posedge pclk);
			case (s)
				0: host_pull <= 1'b1;
				1: periph_pull <= 1'b1;
				2: cs_n <= 1'b0;
				default: port_connected <= 3'h1;
			endcase
			repeat (300) @(posedge pclk);
			host_pull <= 1'b0;
			periph_pull <= 1'b0;
			cs_n <= 1'b1;
			for (int n = 0; n < 5000 && clocks_running_irq !== 1'b1; n++) @(negedge pclk);
			chk("irq", 1, clocks_running_irq);
			apb(0, OFS_STAT, 0);
			chk("stat", {22'h0, 1'(s == 1), 1'(s == 0), 8'h31}, rd);
			chk("main_clk_en", 3'h6, main_clk_en);
			apb(1, OFS_STAT, 1);
			if (s < 3) begin
				repeat (40) @(posedge pclk);
				apb(0, OFS_STAT, 0);
				chk("stat", 32'h10, rd & 32'h31);
			end else begin
				apb(1, OFS_CMD, 1);
				repeat (300) @(posedge pclk);
				apb(0, OFS_STAT, 0);
				chk("stat", 32'h0, rd & 32'h31);
			end
			$display("test wake source %0d done", s);
		end
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (HYB_RST_CYC) @(posedge pclk);
		presetn <= 1'b1;
		@(negedge pclk);
		chk("main_clk_en", 3'h7, main_clk_en);
		chk("host_oe", 1, h_oe);
		chk("block_off", 8'h00, block_off);
		apb(0, OFS_PWRCTL, 0);
		chk("pwrctl", {CLKOFF_RST, 16'h0}, rd);
		apb(0, OFS_CMD, 0);
		chk("cmd", 32'h0, rd);
		$display("test reset done");
		print_verdict();
	end
endmodule : suspend_wake_power_control_bench
